/* seconds_watchdog_defines.svh */
// Register offsets, field positions, reset values and timing counts of the seconds watchdog.
// Assumes an 8-bit register bus with a 4-bit word address.
`ifndef SECONDS_WATCHDOG_DEFINES_SVH
`define SECONDS_WATCHDOG_DEFINES_SVH

`define WD_ADDR_COUNT        4'h0
`define WD_ADDR_CTRL         4'h1
`define WD_ADDR_STATUS       4'h2
`define WD_ADDR_ISTAT        4'h3
`define WD_ADDR_IMASK        4'h4

`define WD_CTRL_EN           0
`define WD_CTRL_IRQEN        1
`define WD_CTRL_RSTEN        2
`define WD_CTRL_SEL_LSB      4
`define WD_CTRL_SEL_MSB      6

`define WD_COUNT_RESET       8'h00
`define WD_SEL_RESET         3'h0

`define WD_CLOCK_PERIOD_NS   5
`define WD_TICK_PERIOD_NS    1000000000
`define WD_TICK_CYCLES       (`WD_TICK_PERIOD_NS / `WD_CLOCK_PERIOD_NS)
`define WD_BOARD_RESET_NS    1000
`define WD_BOARD_RESET_CYCLES \
	((`WD_BOARD_RESET_NS + `WD_CLOCK_PERIOD_NS - 1) / `WD_CLOCK_PERIOD_NS)

`endif

/* seconds_watchdog_pkg.sv */
// Types shared by the seconds watchdog and its prescaler.
// Assumes seconds_watchdog_defines.svh supplies the numbers.
package seconds_watchdog_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_bus_s;

	typedef enum logic [2:0] {
		WD_OFF   = 3'h1,
		WD_RUN   = 3'h2,
		WD_FIRED = 3'h4
	} wd_state_e;

	typedef struct packed {
		logic [27:0] cnt;
		logic        tick;
	} tick_state_s;

	typedef struct packed {
		wd_state_e  state;
		logic [7:0] count;
		logic       enable;
		logic       irq_en;
		logic       rst_en;
		logic [2:0] sel;
		logic       timeout;
		logic       trig_q;
		logic       istat;
		logic       imask;
		logic [7:0] rdata;
		logic       irq;
		logic [7:0] serirq;
		logic       board_rst;
		logic [7:0] rst_cnt;
	} wd_regs_s;

endpackage

/* second_prescaler.sv */
// Divides the system clock down to a one-cycle pulse once per second.
// Assumes restart is a same-clock level; while it is high no tick is produced.
`timescale 1ns/1ps
`include "seconds_watchdog_defines.svh"
module second_prescaler #(
	parameter int unsigned TICK_CYCLES = `WD_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Control
	input  wire logic restart,
	// Tick out
	output logic      tick
);
	import seconds_watchdog_pkg::*;

	localparam logic [27:0] RELOAD = 28'(TICK_CYCLES - 1);

	tick_state_s s;
	tick_state_s next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (restart) begin
			next_s.cnt = RELOAD;
		end else if (s.cnt == 28'h0) begin
			next_s.cnt = RELOAD;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt - 28'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s <= '{cnt: RELOAD, tick: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	chk_tick_spacing: assert property (@(posedge clock) disable iff (sys_rst)
		s.tick |=> !s.tick)
		else $error("Tick lasted more than one cycle.");

endmodule // second_prescaler

/* seconds_watchdog_timer.sv */
// Seconds watchdog: an 8-bit count of seconds, its controls, status and interrupt routing.
// Assumes a same-clock register master with one-cycle strobes and 8-bit data.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "seconds_watchdog_defines.svh"
module seconds_watchdog_timer #(
	parameter int unsigned TICK_CYCLES = `WD_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         sys_rst,
	// Register bus
	input  wire seconds_watchdog_pkg::reg_bus_s bus,
	output logic [7:0]                        read_data,
	// Interrupts
	output logic                              irq_out,
	output logic [7:0]                        serirq_lines,
	// Board reset
	output logic                              board_reset
);
	import seconds_watchdog_pkg::*;

	localparam logic [7:0] RST_CYCLES = 8'(`WD_BOARD_RESET_CYCLES);

	wd_regs_s s;
	wd_regs_s next_s;
	logic     tick;
	logic     wr_count;
	logic     wr_ctrl;
	logic     wr_imask;
	logic     rd_istat;
	logic     trigger;
	logic     restart;

	assign wr_count = bus.wr && (bus.addr == `WD_ADDR_COUNT);
	assign wr_ctrl  = bus.wr && (bus.addr == `WD_ADDR_CTRL);
	assign wr_imask = bus.wr && (bus.addr == `WD_ADDR_IMASK);
	assign rd_istat = bus.rd && (bus.addr == `WD_ADDR_ISTAT);

	// The trigger is a level, so a zero count seen at the moment of enabling fires too.
	assign trigger = s.enable && (s.count == 8'h00);

	// Restarting the prescaler on a count write and holding it while disabled makes the first second after
	// enabling or reloading a full one, which keeps the error band at its zero end.
	assign restart = wr_count || !s.enable;

	second_prescaler #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_prescaler (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (restart),
		.tick    (tick)
	);

	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.trig_q = trigger;

		// Count register: a write loads it, a tick counts it down to zero.
		if (wr_count) begin
			next_s.count = bus.wdata;
		end else if (tick && s.enable && (s.count != 8'h00)) begin
			next_s.count = s.count - 8'h01;
		end

		if (wr_ctrl) begin
			next_s.enable = bus.wdata[`WD_CTRL_EN];
			next_s.irq_en = bus.wdata[`WD_CTRL_IRQEN];
			next_s.rst_en = bus.wdata[`WD_CTRL_RSTEN];
			next_s.sel    = bus.wdata[`WD_CTRL_SEL_MSB:`WD_CTRL_SEL_LSB];
		end
		if (wr_imask) begin
			next_s.imask = bus.wdata[0];
		end

		// Timeout status: cleared by disable or a count write. A trigger beside a disable
		// still sets it, but one beside a count write comes from the count being replaced;
		// letting it win would leave the flag stuck while the new count runs down.
		// A zero written while enabled still fires, one cycle later.
		if (!next_s.enable || wr_count) begin
			next_s.timeout = 1'b0;
		end
		if (trigger && !wr_count) begin
			next_s.timeout = 1'b1;
		end

		// Sticky event bit, read to clear; a new trigger beats the clearing read.
		if (rd_istat) begin
			next_s.istat = 1'b0;
		end
		if (trigger && !s.trig_q) begin
			next_s.istat = 1'b1;
		end
		next_s.irq = next_s.istat && next_s.imask;

		// Board reset pulse of fixed length, started by a fresh expiry.
		if (trigger && !s.trig_q && s.rst_en) begin
			next_s.rst_cnt = RST_CYCLES;
		end else if (s.rst_cnt != 8'h00) begin
			next_s.rst_cnt = s.rst_cnt - 8'h01;
		end
		next_s.board_rst = (next_s.rst_cnt != 8'h00);

		// Serial IRQ routing.
		if (next_s.irq_en && next_s.timeout) begin
			next_s.serirq = 8'h01 << next_s.sel;
		end else begin
			next_s.serirq = 8'h00;
		end

		case (s.state)
			WD_OFF: begin
				if (next_s.enable) begin
					next_s.state = WD_RUN;
				end
			end
			WD_RUN: begin
				if (!next_s.enable) begin
					next_s.state = WD_OFF;
				end else if (next_s.timeout) begin
					next_s.state = WD_FIRED;
				end
			end
			WD_FIRED: begin
				if (!next_s.enable) begin
					next_s.state = WD_OFF;
				end else if (!next_s.timeout) begin
					next_s.state = WD_RUN;
				end
			end
			default: begin
				next_s.state = WD_OFF;
			end
		endcase

		// Read data stand for exactly the cycle after the strobe.
		if (bus.rd) begin
			case (bus.addr)
				`WD_ADDR_COUNT: begin
					next_s.rdata = s.count;
				end
				`WD_ADDR_CTRL: begin
					next_s.rdata = {1'b0, s.sel, 1'b0, s.rst_en, s.irq_en, s.enable};
				end
				`WD_ADDR_STATUS: begin
					next_s.rdata = {4'h0, s.state, s.timeout};
				end
				`WD_ADDR_ISTAT: begin
					next_s.rdata = {7'h00, s.istat};
				end
				`WD_ADDR_IMASK: begin
					next_s.rdata = {7'h00, s.imask};
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s.state     <= WD_OFF;
			s.count     <= `WD_COUNT_RESET;
			s.enable    <= 1'b0;
			s.irq_en    <= 1'b0;
			s.rst_en    <= 1'b0;
			s.sel       <= `WD_SEL_RESET;
			s.timeout   <= 1'b0;
			s.trig_q    <= 1'b0;
			s.istat     <= 1'b0;
			s.imask     <= 1'b0;
			s.rdata     <= 8'h00;
			s.irq       <= 1'b0;
			s.serirq    <= 8'h00;
			s.board_rst <= 1'b0;
			s.rst_cnt   <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	assign read_data    = s.rdata;
	assign irq_out      = s.irq;
	assign serirq_lines = s.serirq;
	assign board_reset  = s.board_rst;

	// Checks.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	chk_reset_values: assert property (disable iff (1'b0)
		sys_rst |=> (!s.enable && s.count == 8'h00 && !board_reset && serirq_lines == 8'h00))
		else $error("Watchdog not disabled with zero count after reset.");

	chk_count_load: assert property (
		wr_count |=> s.count == $past(bus.wdata))
		else $error("Count write not loaded.");

	chk_count_down: assert property (
		(tick && s.enable && s.count != 8'h00 && !wr_count)
		|=> s.count == $past(s.count) - 8'h01)
		else $error("Count did not drop by one on the second tick.");

	chk_count_hold: assert property (
		(!tick && !wr_count) |=> s.count == $past(s.count))
		else $error("Count changed without a tick or write.");

	chk_trigger_flag: assert property (
		(s.enable && s.count == 8'h00 && !wr_count && !wr_ctrl)
		|=> s.timeout ##0 s.state == WD_FIRED)
		else $error("Enabled zero count did not raise timeout.");

	chk_flag_clear: assert property (
		(wr_count || (!s.enable && !wr_ctrl)) |=> !s.timeout)
		else $error("Timeout not cleared by disable or count write.");

	chk_serirq_route: assert property (
		serirq_lines == ((s.irq_en && s.timeout) ? (8'h01 << s.sel) : 8'h00))
		else $error("Serial IRQ line does not match select and status.");

	chk_reset_pulse: assert property (
		(trigger && !s.trig_q && s.rst_en) |=> board_reset [*8])
		else $error("Board reset pulse missing or short.");

	chk_no_reset: assert property (
		(!s.rst_en && s.rst_cnt <= 8'h01) |=> !board_reset)
		else $error("Board reset with reset enable clear.");

	chk_restart_tick: assert property (
		wr_count |=> !tick ##1 !tick)
		else $error("Prescaler ticked right after a count write.");

	chk_irq_level: assert property (
		irq_out == (s.istat && s.imask))
		else $error("Interrupt output does not follow unmasked status.");

	chk_read_pulse: assert property (
		!bus.rd |=> read_data == 8'h00)
		else $error("Read data stood outside the read cycle.");

	chk_state_fired: assert property (
		(s.state == WD_FIRED) |-> (s.timeout && s.enable))
		else $error("Fired state without an enabled timeout.");

	chk_event_set: assert property (
		(trigger && !s.trig_q) |=> s.istat)
		else $error("Fresh expiry did not set the event bit.");

	chk_event_read: assert property (
		(rd_istat && !(trigger && !s.trig_q)) |=> !s.istat)
		else $error("Reading the event bit did not clear it.");

	chk_ctrl_load: assert property (
		wr_ctrl |=> (s.sel == $past(bus.wdata[`WD_CTRL_SEL_MSB:`WD_CTRL_SEL_LSB])
			&& s.enable == $past(bus.wdata[`WD_CTRL_EN])))
		else $error("Control write not loaded.");

	chk_serirq_quiet: assert property (
		!s.timeout |-> serirq_lines == 8'h00)
		else $error("Serial IRQ line driven without timeout status.");

	chk_read_count: assert property (
		(bus.rd && bus.addr == `WD_ADDR_COUNT) |=> read_data == $past(s.count))
		else $error("Count read returned a wrong value.");

	chk_enable_run: assert property (
		(wr_ctrl && bus.wdata[`WD_CTRL_EN]) |=> s.state != WD_OFF)
		else $error("Watchdog stayed off after enabling.");

	chk_imask_load: assert property (
		wr_imask |=> s.imask == $past(bus.wdata[0]))
		else $error("Mask write not loaded.");

	chk_count_floor: assert property (
		(s.count == 8'h00 && !wr_count) |=> s.count == 8'h00)
		else $error("Count moved below zero.");

	chk_status_read: assert property (
		(bus.rd && bus.addr == `WD_ADDR_STATUS) |=> read_data[0] == $past(s.timeout))
		else $error("Status read does not show the timeout flag.");

	cov_trigger: cover property (s.enable && s.count == 8'h01 && tick ##2 s.timeout);
	cov_reset: cover property ($rose(board_reset));
	cov_irq: cover property ($rose(irq_out));
	cov_reload: cover property (s.timeout ##1 wr_count ##1 !s.timeout);
	cov_no_reset: cover property (trigger && !s.trig_q && !s.rst_en);

endmodule // seconds_watchdog_timer

/* seconds_watchdog_timer_tb.sv */
// Self-checking bench for the seconds watchdog, driven over its plain register port.
// Assumes the package, the prescaler and the watchdog are compiled ahead of this file.
`timescale 1ns/1ps
`include "seconds_watchdog_defines.svh"
module seconds_watchdog_timer_tb;
	import seconds_watchdog_pkg::*;
	// A short second keeps the run small; the second-long waits below are derived from it.
	localparam int T = 20;
	logic       clock;
	logic       sys_rst;
	reg_bus_s   bus;
	logic [7:0] read_data;
	logic       irq_out;
	logic [7:0] serirq_lines;
	logic       board_reset;
	int         fail_count;
	int         n_compared;
	int         n;

	seconds_watchdog_timer #(.TICK_CYCLES(T)) seconds_watchdog_timer_i (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.bus          (bus),
		.read_data    (read_data),
		.irq_out      (irq_out),
		.serirq_lines (serirq_lines),
		.board_reset  (board_reset)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		bus.addr  <= a;
		bus.wdata <= v;
		bus.wr    <= 1'b1;
		@(posedge clock);
		bus.wr    <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge clock);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clock);
		bus.rd   <= 1'b0;
		#1 chk8(read_data, exp, what);
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask

	initial begin
		repeat (12000) @(posedge clock);
		fail_count++;
		$display("MISMATCH at %0t: run hung", $time);
		tally_and_finish();
	end

	initial begin
		sys_rst = 1'b1;
		bus = '0;
		fail_count = 0;
		n_compared = 0;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		rd(`WD_ADDR_COUNT, 8'h00, "count reset");
		rd(`WD_ADDR_CTRL, 8'h00, "ctrl reset");
		rd(`WD_ADDR_STATUS, 8'h02, "status reset");
		wr(`WD_ADDR_COUNT, 8'hFF);
		rd(`WD_ADDR_COUNT, 8'hFF, "count max");
		wr(`WD_ADDR_CTRL, 8'hFE);
		rd(`WD_ADDR_CTRL, 8'h76, "ctrl fields");
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00, "unmapped");
		wr(`WD_ADDR_CTRL, 8'h00);
		wr(`WD_ADDR_COUNT, 8'h00);
		$display("test registers done");

		wr(`WD_ADDR_CTRL, 8'h01);
		idle(3);
		rd(`WD_ADDR_STATUS, 8'h09, "fired at enable");
		chkb(irq_out, 1'b0, "masked irq");
		wr(`WD_ADDR_IMASK, 8'h01);
		idle(2);
		chkb(irq_out, 1'b1, "unmasked irq");
		rd(`WD_ADDR_ISTAT, 8'h01, "event sticky");
		idle(2);
		chkb(irq_out, 1'b0, "irq after read");
		rd(`WD_ADDR_ISTAT, 8'h00, "event cleared");
		wr(`WD_ADDR_COUNT, 8'h05);
		rd(`WD_ADDR_STATUS, 8'h04, "count write clears");
		wr(`WD_ADDR_CTRL, 8'h00);
		rd(`WD_ADDR_STATUS, 8'h02, "disable clears");
		wr(`WD_ADDR_IMASK, 8'h00);
		$display("test immediate trigger done");

		for (int s = 0; s < 8; s++) begin
			wr(`WD_ADDR_COUNT, 8'h01);
			wr(`WD_ADDR_CTRL, {1'b0, s[2:0], 4'h3});
			chk8(serirq_lines, 8'h00, "irq early");
			idle(T + 6);
			chk8(serirq_lines, 8'(8'h01 << s), "irq line");
			wr(`WD_ADDR_CTRL, {1'b0, s[2:0], 4'h1});
			idle(2);
			chk8(serirq_lines, 8'h00, "irq enable off");
			wr(`WD_ADDR_CTRL, 8'h00);
		end
		$display("test irq select done");

		// The trigger comes a full count of seconds after enabling or reloading, never early.
		wr(`WD_ADDR_COUNT, 8'h03);
		wr(`WD_ADDR_CTRL, 8'h01);
		idle(T + 4);
		rd(`WD_ADDR_COUNT, 8'h02, "one second down");
		idle(T - 8);
		rd(`WD_ADDR_STATUS, 8'h04, "not yet fired");
		wr(`WD_ADDR_COUNT, 8'h03);
		idle(2 * T - 6);
		rd(`WD_ADDR_STATUS, 8'h04, "reload holds off");
		idle(T + 8);
		rd(`WD_ADDR_STATUS, 8'h09, "fired on time");
		wr(`WD_ADDR_CTRL, 8'h00);
		$display("test timing done");

		wr(`WD_ADDR_COUNT, 8'h00);
		for (int r = 1; r >= 0; r--) begin
			wr(`WD_ADDR_CTRL, {5'h00, r[0], 2'h1});
			n = 0;
			repeat (300) begin
				@(posedge clock);
				#1 n += board_reset;
			end
			chk8(8'(n), r ? 8'(`WD_BOARD_RESET_CYCLES) : 8'h00, "reset pulse");
			wr(`WD_ADDR_CTRL, 8'h00);
		end
		$display("test board reset done");
		tally_and_finish();
	end
endmodule // seconds_watchdog_timer_tb
